//--- rtl/adc_port_host.sv
// Our own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module adc_port_host
  import adc_port_pkg::*;
#(
  parameter bit WIDE = 1'b1
)
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  adc_port_if.host port
);
  localparam logic [1:0] HOLD_LAST = 2'(DIRECT_HOLD - 1);

  typedef struct packed {
    logic ctrl_mode;
    logic ctrl_run;
    logic mode_out;
    logic aw_have;
    logic w_have;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [FIFO_DEPTH-1:0][FIFO_W-1:0] mem;
    logic rd_ptr;
    logic wr_ptr;
    logic [1:0] count;
    logic send_en;
    logic ovf;
    logic strobe_prev;
    logic busy;
    logic [1:0] hold_cnt;
    logic [1:0] sel;
    logic [7:0] direct_data;
    logic low_o;
    logic mid_o;
    logic high_o;
    logic ce_o;
    logic drive;
  } host_s;

  host_s q;
  host_s d;

  // byte as seen on the result pins for a given byte id
  function automatic logic [7:0] pick(input logic [1:0] id, input logic [15:0] b, input logic p, input logic o);
    logic [7:0] r;
    r = b[7:0];
    if (id == BYTE_HIGH)
    begin
      r = WIDE ? {6'h00, o, p} : {o, p, b[13:8]};
    end
    else if (id == BYTE_MID)
    begin
      r = b[15:8];
    end
    return r;
  endfunction : pick

  always_comb
  begin
    logic push;
    logic pop;
    logic [1:0] flag_id;
    push = 1'b0;
    pop = 1'b0;
    flag_id = BYTE_LOW;
    d = q;
    d.mode_out = q.ctrl_mode;
    d.strobe_prev = port.chip_enable_load_strobe;
    // handshake capture on the falling load strobe
    if (!port.high_byte_enable)
    begin
      flag_id = BYTE_HIGH;
    end
    else if (WIDE && !port.middle_byte_enable)
    begin
      flag_id = BYTE_MID;
    end
    if (!q.drive && q.strobe_prev && !port.chip_enable_load_strobe)
    begin
      if (q.count < 2'(FIFO_DEPTH))
      begin
        push = 1'b1;
      end
      else
      begin
        d.ovf = 1'b1;
      end
    end
    // axi write
    if (s_axi_awvalid && q.awready)
    begin
      d.aw_have = 1'b1;
      d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready)
    begin
      d.w_have = 1'b1;
      d.wdata = s_axi_wdata;
    end
    if (q.bvalid && s_axi_bready)
    begin
      d.bvalid = 1'b0;
    end
    if (d.aw_have && d.w_have && !q.bvalid)
    begin
      d.aw_have = 1'b0;
      d.w_have = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = RESP_OKAY;
      if (d.awaddr == CTRL_OFS)
      begin
        if (s_axi_wstrb[0])
        begin
          d.ctrl_mode = d.wdata[CTRL_MODE_BIT];
          d.ctrl_run = d.wdata[CTRL_RUN_BIT];
          d.mode_out = d.wdata[CTRL_MODE_BIT] | d.wdata[CTRL_PULSE_BIT];
        end
      end
      else if (d.awaddr == DIRECT_OFS)
      begin
        if (!q.busy && !q.ctrl_mode)
        begin
          d.busy = 1'b1;
          d.hold_cnt = 2'h0;
          d.sel = d.wdata[1:0];
        end
      end
      else if (d.awaddr == STATUS_OFS)
      begin
        if (d.wdata[STATUS_OVF_BIT] && !(d.ovf && !q.ovf))
        begin
          d.ovf = 1'b0;
        end
      end
      else if (d.awaddr != RXDATA_OFS && d.awaddr != DIRECT_DATA_OFS)
      begin
        d.bresp = RESP_SLVERR;
      end
    end
    // axi read
    if (q.rvalid && s_axi_rready)
    begin
      d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && q.arready)
    begin
      d.rvalid = 1'b1;
      d.rresp = RESP_OKAY;
      d.rdata = 32'h0;
      if (s_axi_araddr == CTRL_OFS)
      begin
        d.rdata[CTRL_MODE_BIT] = q.ctrl_mode;
        d.rdata[CTRL_RUN_BIT] = q.ctrl_run;
      end
      else if (s_axi_araddr == DIRECT_OFS)
      begin
        d.rdata[1:0] = q.sel;
      end
      else if (s_axi_araddr == RXDATA_OFS)
      begin
        if (q.count != 2'h0)
        begin
          pop = 1'b1;
          d.rdata[FIFO_W-1:0] = q.mem[q.rd_ptr];
          d.rdata[RXDATA_VALID_BIT] = 1'b1;
        end
      end
      else if (s_axi_araddr == STATUS_OFS)
      begin
        d.rdata[0] = port.conversion_status;
        d.rdata[2:1] = q.count;
        d.rdata[3] = q.busy;
        d.rdata[STATUS_OVF_BIT] = q.ovf;
      end
      else if (s_axi_araddr == DIRECT_DATA_OFS)
      begin
        d.rdata[7:0] = q.direct_data;
      end
      else
      begin
        d.rresp = RESP_SLVERR;
      end
    end
    // two-entry receive buffer
    if (push)
    begin
      d.mem[q.wr_ptr] = {flag_id, pick(flag_id, port.bits_pin, port.polarity_pin, port.overrange_pin)};
      d.wr_ptr = ~q.wr_ptr;
    end
    if (pop)
    begin
      d.rd_ptr = ~q.rd_ptr;
    end
    d.count = q.count + {1'b0, push} - {1'b0, pop};
    d.send_en = (d.count < 2'(FIFO_DEPTH));
    // direct read: hold chip enable and one byte enable low, sample on last cycle
    if (q.busy)
    begin
      if (q.hold_cnt == HOLD_LAST)
      begin
        d.busy = 1'b0;
        d.direct_data = pick(q.sel, port.bits_pin, port.polarity_pin, port.overrange_pin);
      end
      else
      begin
        d.hold_cnt = q.hold_cnt + 2'h1;
      end
    end
    d.drive = d.busy;
    d.ce_o = !d.busy;
    d.low_o = !(d.busy && d.sel == BYTE_LOW);
    d.mid_o = !(d.busy && d.sel == BYTE_MID);
    d.high_o = !(d.busy && d.sel == BYTE_HIGH);
    d.awready = !d.aw_have && !d.bvalid;
    d.wready = !d.w_have && !d.bvalid;
    d.arready = !d.rvalid;
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      q <= '0;
      q.ctrl_mode <= CTRL_MODE_RESET;
      q.ctrl_run <= CTRL_RUN_RESET;
      q.mode_out <= CTRL_MODE_RESET;
      q.awready <= 1'b1;
      q.wready <= 1'b1;
      q.arready <= 1'b1;
      q.send_en <= 1'b1;
      q.strobe_prev <= 1'b1;
      q.low_o <= 1'b1;
      q.mid_o <= 1'b1;
      q.high_o <= 1'b1;
      q.ce_o <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign port.mode = q.mode_out;
  assign port.run_hold = q.ctrl_run;
  assign port.send_enable = q.send_en;
  assign port.low_byte_enable_host = q.low_o;
  assign port.low_byte_enable_host_oe = q.drive;
  assign port.middle_byte_enable_host = q.mid_o;
  assign port.middle_byte_enable_host_oe = q.drive & WIDE;
  assign port.high_byte_enable_host = q.high_o;
  assign port.high_byte_enable_host_oe = q.drive;
  assign port.chip_enable_load_strobe_host = q.ce_o;
  assign port.chip_enable_load_strobe_host_oe = q.drive;
endmodule : adc_port_host

//--- rtl/adc_port_pkg.sv
package adc_port_pkg;
  // conversion cycle length as a power of two, wide and narrow variant
  localparam int CONV_LOG2_WIDE = 17;
  localparam int CONV_LOG2_NARROW = 15;
  // park point ahead of input integration
  localparam int HALT_LEAD = 7;
  // auto-zero phase is the first 1/4 of the cycle
  localparam int AZ_SHIFT = 2;
  localparam int STROBE_CYCLES = 2;
  localparam int DIRECT_HOLD = 3;
  localparam int FIFO_DEPTH = 2;
  localparam int FIFO_W = 10;
  localparam logic [1:0] BYTE_LOW = 2'h0;
  localparam logic [1:0] BYTE_MID = 2'h1;
  localparam logic [1:0] BYTE_HIGH = 2'h2;
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] DIRECT_OFS = 8'h04;
  localparam logic [7:0] RXDATA_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0c;
  localparam logic [7:0] DIRECT_DATA_OFS = 8'h10;
  localparam int CTRL_MODE_BIT = 0;
  localparam int CTRL_RUN_BIT = 1;
  localparam int CTRL_PULSE_BIT = 2;
  localparam logic CTRL_MODE_RESET = 1'h0;
  localparam logic CTRL_RUN_RESET = 1'h1;
  localparam int STATUS_OVF_BIT = 4;
  localparam int RXDATA_VALID_BIT = 31;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : adc_port_pkg

//--- rtl/adc_port_if.sv
`timescale 1ns/1ps
interface adc_port_if;
  logic [15:0] result_bits;
  logic [2:0] result_oe;
  logic polarity_out;
  logic overrange_out;
  logic conversion_status;
  logic rc_osc_node;
  logic mode;
  logic run_hold;
  logic send_enable;
  logic low_byte_enable_dev;
  logic low_byte_enable_dev_oe;
  logic low_byte_enable_host;
  logic low_byte_enable_host_oe;
  logic middle_byte_enable_dev;
  logic middle_byte_enable_dev_oe;
  logic middle_byte_enable_host;
  logic middle_byte_enable_host_oe;
  logic high_byte_enable_dev;
  logic high_byte_enable_dev_oe;
  logic high_byte_enable_host;
  logic high_byte_enable_host_oe;
  logic chip_enable_load_strobe_dev;
  logic chip_enable_load_strobe_dev_oe;
  logic chip_enable_load_strobe_host;
  logic chip_enable_load_strobe_host_oe;
  // resolved wire levels; undriven enables float high on their pullups
  logic low_byte_enable;
  logic middle_byte_enable;
  logic high_byte_enable;
  logic chip_enable_load_strobe;
  logic [15:0] bits_pin;
  logic polarity_pin;
  logic overrange_pin;
  assign low_byte_enable = low_byte_enable_dev_oe ? low_byte_enable_dev :
                           (low_byte_enable_host_oe ? low_byte_enable_host : 1'b1);
  assign middle_byte_enable = middle_byte_enable_dev_oe ? middle_byte_enable_dev :
                              (middle_byte_enable_host_oe ? middle_byte_enable_host : 1'b1);
  assign high_byte_enable = high_byte_enable_dev_oe ? high_byte_enable_dev :
                            (high_byte_enable_host_oe ? high_byte_enable_host : 1'b1);
  assign chip_enable_load_strobe = chip_enable_load_strobe_dev_oe ? chip_enable_load_strobe_dev :
                                   (chip_enable_load_strobe_host_oe ? chip_enable_load_strobe_host : 1'b1);
  assign bits_pin[7:0] = result_oe[0] ? result_bits[7:0] : 8'h00;
  assign bits_pin[15:8] = result_oe[1] ? result_bits[15:8] : 8'h00;
  assign polarity_pin = result_oe[2] ? polarity_out : 1'b0;
  assign overrange_pin = result_oe[2] ? overrange_out : 1'b0;
  modport device (
    output result_bits, result_oe, polarity_out, overrange_out, conversion_status, rc_osc_node,
    input mode, run_hold, send_enable,
    output low_byte_enable_dev, low_byte_enable_dev_oe, middle_byte_enable_dev, middle_byte_enable_dev_oe,
    output high_byte_enable_dev, high_byte_enable_dev_oe,
    output chip_enable_load_strobe_dev, chip_enable_load_strobe_dev_oe,
    input low_byte_enable, middle_byte_enable, high_byte_enable, chip_enable_load_strobe
  );
  modport host (
    input bits_pin, polarity_pin, overrange_pin, conversion_status, rc_osc_node,
    output mode, run_hold, send_enable,
    output low_byte_enable_host, low_byte_enable_host_oe, middle_byte_enable_host, middle_byte_enable_host_oe,
    output high_byte_enable_host, high_byte_enable_host_oe,
    output chip_enable_load_strobe_host, chip_enable_load_strobe_host_oe,
    input low_byte_enable, middle_byte_enable, high_byte_enable, chip_enable_load_strobe
  );
endinterface : adc_port_if

//--- rtl/adc_port_device.sv
// Functional notes
// - low enable with chip enable drives bits 1-8
// - handshake drives low enable as byte flag
// - wide: middle enable gates bits 9-16
// - narrow: high enable gates bits 9-14, polarity, overrange
// - wide: high enable gates polarity, overrange only
// - mode low: enables are inputs gating bytes
// - mode pulse enters handshake at once
// - mode high: enables output, handshake after conversion
// - run high: conversion every 2^17 or 2^15 clocks
// - run low: park seven counts before integration
// - send enable high permits next byte
// - mode low: chip enable high disables all result outputs
// - mode high: chip enable is falling load strobe
// - narrow: oscillator node gives clock output
// - status high integrate until latch, low auto-zero
// - polarity three-state, high for positive input
// - result bits three-state, active high, byte gated
`timescale 1ns/1ps
module adc_port_device
  import adc_port_pkg::*;
#(
  parameter bit WIDE = 1'b1,
  parameter int CONV_CYCLES = WIDE ? (1 << CONV_LOG2_WIDE) : (1 << CONV_LOG2_NARROW)
)
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [15:0] sample_value,
  input wire logic sample_positive,
  input wire logic sample_overrange,
  adc_port_if.device port
);
  localparam logic [16:0] LAST = 17'(CONV_CYCLES - 1);
  localparam logic [16:0] AZ_END = 17'(CONV_CYCLES >> AZ_SHIFT);
  localparam logic [16:0] HALT_AT = 17'((CONV_CYCLES >> AZ_SHIFT) - HALT_LEAD);
  localparam logic [1:0] STROBE_LAST = 2'(STROBE_CYCLES - 1);

  typedef enum logic [2:0] {
    st_direct,
    st_wait_send,
    st_present,
    st_strobe,
    st_release
  } dev_state_e;

  typedef struct packed {
    dev_state_e st;
    logic [16:0] cnt;
    logic [15:0] result;
    logic positive;
    logic overrange;
    logic status;
    logic mode_prev;
    logic [1:0] byte_id;
    logic [1:0] wait_cnt;
    logic [2:0] result_oe;
    logic low_o;
    logic mid_o;
    logic high_o;
    logic ce_o;
    logic pins_oe;
    logic osc;
  } dev_s;

  dev_s q;
  dev_s d;

  always_comb
  begin
    logic conv_done;
    logic start_hs;
    logic [2:0] group_oe;
    conv_done = 1'b0;
    start_hs = 1'b0;
    group_oe = 3'h0;
    d = q;
    d.mode_prev = port.mode;
    d.osc = WIDE ? 1'b0 : ~q.osc;
    // conversion sequencer
    if (q.cnt == HALT_AT && !port.run_hold)
    begin
      d.cnt = q.cnt;
    end
    else if (q.cnt == LAST)
    begin
      d.cnt = 17'h0;
      conv_done = 1'b1;
    end
    else
    begin
      d.cnt = q.cnt + 17'h1;
    end
    d.status = (d.cnt >= AZ_END);
    // result is frozen while a handshake is sending it
    if (conv_done && q.st == st_direct)
    begin
      d.result = WIDE ? sample_value : {2'h0, sample_value[13:0]};
      d.positive = sample_positive;
      d.overrange = sample_overrange;
    end
    // byte group driven for the current handshake byte
    if (q.byte_id == BYTE_HIGH)
    begin
      group_oe = WIDE ? 3'h4 : 3'h6;
    end
    else if (q.byte_id == BYTE_MID)
    begin
      group_oe = 3'h2;
    end
    else
    begin
      group_oe = 3'h1;
    end
    case (q.st)
      st_direct:
      begin
        d.low_o = 1'b1;
        d.mid_o = 1'b1;
        d.high_o = 1'b1;
        d.ce_o = 1'b1;
        d.result_oe = 3'h0;
        if (!port.mode && !port.chip_enable_load_strobe)
        begin
          d.result_oe[0] = !port.low_byte_enable;
          if (WIDE)
          begin
            d.result_oe[1] = !port.middle_byte_enable;
            d.result_oe[2] = !port.high_byte_enable;
          end
          else
          begin
            d.result_oe[1] = !port.high_byte_enable;
            d.result_oe[2] = !port.high_byte_enable;
          end
        end
        if (port.mode && !q.mode_prev)
        begin
          start_hs = 1'b1;
        end
        if (conv_done && port.mode)
        begin
          start_hs = 1'b1;
        end
        if (start_hs)
        begin
          d.st = st_wait_send;
          d.byte_id = BYTE_HIGH;
          d.result_oe = 3'h0;
        end
      end
      st_wait_send:
      begin
        if (port.send_enable)
        begin
          d.st = st_present;
          d.result_oe = group_oe;
          d.low_o = (q.byte_id != BYTE_LOW);
          d.mid_o = !(WIDE && q.byte_id == BYTE_MID);
          d.high_o = (q.byte_id != BYTE_HIGH);
        end
      end
      st_present:
      begin
        d.st = st_strobe;
        d.ce_o = 1'b0;
        d.wait_cnt = 2'h0;
      end
      st_strobe:
      begin
        if (q.wait_cnt == STROBE_LAST)
        begin
          d.st = st_release;
          d.ce_o = 1'b1;
        end
        else
        begin
          d.wait_cnt = q.wait_cnt + 2'h1;
        end
      end
      st_release:
      begin
        d.low_o = 1'b1;
        d.mid_o = 1'b1;
        d.high_o = 1'b1;
        d.result_oe = 3'h0;
        if (q.byte_id == BYTE_LOW)
        begin
          d.st = st_direct;
        end
        else
        begin
          d.st = st_wait_send;
          d.byte_id = (q.byte_id == BYTE_HIGH && WIDE) ? BYTE_MID : BYTE_LOW;
        end
      end
      default:
      begin
        d.st = st_direct;
      end
    endcase
    d.pins_oe = port.mode || (d.st != st_direct);
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      q <= '0;
      q.st <= st_direct;
      q.low_o <= 1'b1;
      q.mid_o <= 1'b1;
      q.high_o <= 1'b1;
      q.ce_o <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  assign port.result_bits = q.result;
  assign port.result_oe = q.result_oe;
  assign port.polarity_out = q.positive;
  assign port.overrange_out = q.overrange;
  assign port.conversion_status = q.status;
  assign port.rc_osc_node = q.osc;
  assign port.low_byte_enable_dev = q.low_o;
  assign port.low_byte_enable_dev_oe = q.pins_oe;
  assign port.middle_byte_enable_dev = q.mid_o;
  assign port.middle_byte_enable_dev_oe = q.pins_oe & WIDE;
  assign port.high_byte_enable_dev = q.high_o;
  assign port.high_byte_enable_dev_oe = q.pins_oe;
  assign port.chip_enable_load_strobe_dev = q.ce_o;
  assign port.chip_enable_load_strobe_dev_oe = q.pins_oe;
endmodule : adc_port_device

//--- testbench/adc_port_properties.sv
`timescale 1ns/1ps
module adc_port_properties
  import adc_port_pkg::*;
#(
  parameter bit WIDE = 1'b1,
  parameter int CONV_CYCLES = 64
)
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic mode,
  input wire logic run_hold,
  input wire logic send_enable,
  input wire logic low_byte_enable,
  input wire logic middle_byte_enable,
  input wire logic high_byte_enable,
  input wire logic chip_enable_load_strobe,
  input wire logic chip_enable_load_strobe_dev_oe,
  input wire logic [2:0] result_oe,
  input wire logic conversion_status
);
  typedef struct packed {
    logic [1:0] last;
    logic stat;
    logic seen;
    logic [15:0] gap;
    logic [15:0] hold;
  } mon_s;
  mon_s mon_q;
  mon_s mon_d;
  wire hs = chip_enable_load_strobe_dev_oe;
  wire rise = conversion_status && !mon_q.stat;
  wire lo_sel = !chip_enable_load_strobe && !low_byte_enable;
  wire mid_sel = !chip_enable_load_strobe && !(WIDE ? middle_byte_enable : high_byte_enable);
  wire hi_sel = !chip_enable_load_strobe && !high_byte_enable;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  // gap: cycles since last status rise, hold: cycles with run_hold low
  always_comb
  begin
    mon_d = mon_q;
    mon_d.stat = conversion_status;
    mon_d.gap = rise ? 16'h0 : mon_q.gap + 16'h1;
    mon_d.seen = run_hold && (mon_q.seen || rise);
    mon_d.hold = run_hold ? 16'h0 : mon_q.hold + {15'h0, ~&mon_q.hold};
    if (hs && !high_byte_enable)
      mon_d.last = BYTE_HIGH;
    if (hs && !middle_byte_enable)
      mon_d.last = BYTE_MID;
  end
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      mon_q <= '0;
    else
      mon_q <= mon_d;
  end
  sequence s_direct;
    !mode && !hs && !$past(hs) && !$past(hs, 2);
  endsequence
  property p_low_gate;
    s_direct |-> result_oe[0] == $past(lo_sel);
  endproperty
  a_low_gate: assert property (p_low_gate) else $error("low byte gating wrong");
  property p_mid_gate;
    s_direct |-> result_oe[1] == $past(mid_sel);
  endproperty
  a_mid_gate: assert property (p_mid_gate) else $error("middle byte gating wrong");
  property p_high_gate;
    s_direct |-> result_oe[2] == $past(hi_sel);
  endproperty
  a_high_gate: assert property (p_high_gate) else $error("sign byte gating wrong");
  property p_strobe;
    hs && $fell(chip_enable_load_strobe) |-> !chip_enable_load_strobe [*2] ##[1:2] chip_enable_load_strobe;
  endproperty
  a_strobe: assert property (p_strobe) else $error("load strobe width wrong");
  property p_one_flag;
    hs && !chip_enable_load_strobe |-> $onehot({!low_byte_enable, !middle_byte_enable, !high_byte_enable});
  endproperty
  a_one_flag: assert property (p_one_flag) else $error("byte flag not unique");
  property p_send;
    hs && $fell(low_byte_enable && middle_byte_enable && high_byte_enable) |-> $past(send_enable);
  endproperty
  a_send: assert property (p_send) else $error("byte sent without send enable");
  property p_order;
    hs && $fell(middle_byte_enable) |-> mon_q.last == BYTE_HIGH;
  endproperty
  a_order: assert property (p_order) else $error("middle byte not after high byte");
  property p_mode_out;
    mode |=> hs;
  endproperty
  a_mode_out: assert property (p_mode_out) else $error("pins not outputs with mode high");
  property p_status;
    $rose(conversion_status) |-> conversion_status [*8];
  endproperty
  a_status: assert property (p_status) else $error("status dropped early");
  property p_period;
    rise && mon_q.seen |-> mon_q.gap == 16'(CONV_CYCLES - 1);
  endproperty
  a_period: assert property (p_period) else $error("conversion period wrong");
  property p_park;
    mon_q.hold > 16'(CONV_CYCLES + 4) |-> !conversion_status;
  endproperty
  a_park: assert property (p_park) else $error("no park in auto-zero");
endmodule : adc_port_properties

//--- testbench/dual_slope_adc_byte_output_port_test.sv
`timescale 1ns/1ps
module dual_slope_adc_byte_output_port_test
  import adc_port_pkg::*;
;
  localparam int CONV = 64;
  localparam logic [15:0] SAMP = 16'hc3a5;
  typedef struct packed {
    logic rd;
    logic [7:0] addr;
    logic [31:0] data;
    logic [31:0] mask;
    logic [1:0] resp;
  } row_s;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rdat;
  int fails = 0;
  int check_count = 0;
  logic [7:0] exb [3] = '{SAMP[7:0], SAMP[15:8], 8'h01};
  row_s rows [11] = '{
    '{1'b1, STATUS_OFS, 32'h0, 32'h1e, RESP_OKAY},
    '{1'b0, DIRECT_OFS, 32'h0, 32'h0, RESP_OKAY},
    '{1'b1, DIRECT_DATA_OFS, {24'h0, SAMP[7:0]}, 32'hff, RESP_OKAY},
    '{1'b0, DIRECT_OFS, 32'h1, 32'h0, RESP_OKAY},
    '{1'b1, DIRECT_DATA_OFS, {24'h0, SAMP[15:8]}, 32'hff, RESP_OKAY},
    '{1'b0, DIRECT_OFS, 32'h2, 32'h0, RESP_OKAY},
    '{1'b1, DIRECT_DATA_OFS, 32'h1, 32'hff, RESP_OKAY},
    '{1'b1, 8'h14, 32'h0, 32'hffffffff, RESP_SLVERR},
    '{1'b0, 8'h40, 32'h0, 32'h0, RESP_SLVERR},
    '{1'b0, RXDATA_OFS, 32'h5, 32'h0, RESP_OKAY},
    '{1'b1, RXDATA_OFS, 32'h0, 32'h80000000, RESP_OKAY}};
  adc_port_if w();
  always #2 core_clk = ~core_clk;
  adc_port_device #(.WIDE(1'b1), .CONV_CYCLES(CONV)) i_adc_port_device (.core_clk, .nrst,
    .sample_value(SAMP), .sample_positive(1'b1), .sample_overrange(1'b0), .port(w.device));
  adc_port_host #(.WIDE(1'b1)) i_adc_port_host (.core_clk, .nrst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .port(w.host));
  adc_port_properties #(.WIDE(1'b1), .CONV_CYCLES(CONV)) i_adc_port_properties (.core_clk(core_clk),
    .nrst(nrst), .mode(w.mode), .run_hold(w.run_hold), .send_enable(w.send_enable),
    .low_byte_enable(w.low_byte_enable), .middle_byte_enable(w.middle_byte_enable),
    .high_byte_enable(w.high_byte_enable), .chip_enable_load_strobe(w.chip_enable_load_strobe),
    .chip_enable_load_strobe_dev_oe(w.chip_enable_load_strobe_dev_oe), .result_oe(w.result_oe),
    .conversion_status(w.conversion_status));
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic close_out;
    if (fails == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : close_out
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge core_clk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    rdat = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic wait_status(input logic [31:0] mask, input logic [31:0] val);
    int n;
    n = 0;
    do
    begin
      rd(STATUS_OFS);
      n++;
    end
    while ((rdat & mask) !== val && n < 200);
    check("status", rdat & mask, val);
  endtask : wait_status
  // full buffer stalls the sender, then pops come out high byte first
  task automatic burst(input logic [31:0] ctrl);
    int n;
    wr(CTRL_OFS, ctrl);
    wait_status(32'h6, 32'h4);
    check("send_enable", 32'(w.send_enable), 32'h0);
    for (int i = 2; i >= 0; i--)
    begin
      n = 0;
      do
      begin
        rd(RXDATA_OFS);
        n++;
      end
      while (rdat[31] !== 1'b1 && n < 50);
      check("rx_byte", rdat & 32'h800003ff, {1'b1, 21'h0, 2'(i), exb[i]});
    end
    wait_status(32'h10, 32'h0);
  endtask : burst
  always @(posedge core_clk)
  begin
    if (nrst && w.result_oe[0])
      check("low_pins", 32'(w.bits_pin[7:0]), 32'(SAMP[7:0]));
    if (nrst && w.result_oe[1])
      check("mid_pins", 32'(w.bits_pin[15:8]), 32'(SAMP[15:8]));
    if (nrst && w.result_oe[2])
      check("sign_pins", 32'({w.overrange_pin, w.polarity_pin}), 32'h1);
  end
  initial
  begin
    repeat (60000) @(posedge core_clk);
    fails++;
    $display("[ERR] watchdog expected done seen hang");
    close_out();
  end
  initial
  begin
    repeat (10) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (2 * CONV) @(posedge core_clk);
    foreach (rows[i])
    begin
      if (rows[i].rd)
        rd(rows[i].addr);
      else
        wr(rows[i].addr, rows[i].data);
      check("resp", 32'(rsp), 32'(rows[i].resp));
      if (rows[i].rd)
        check("data", rdat & rows[i].mask, rows[i].data);
      else
        wait_status(32'h8, 32'h0);
    end
    burst(32'h6);
    burst(32'h3);
    // mode still high: next conversion end refills the buffer
    wait_status(32'h6, 32'h4);
    wr(CTRL_OFS, 32'h0);
    repeat (2 * CONV) @(posedge core_clk);
    check("parked", 32'(w.conversion_status), 32'h0);
    wr(CTRL_OFS, 32'h2);
    wait_status(32'h1, 32'h1);
    @(posedge core_clk);
    nrst <= 1'b0;
    repeat (10) @(posedge core_clk);
    check("reset_pins", 32'({w.chip_enable_load_strobe, w.result_oe}), 32'h8);
    check("osc_node", 32'(w.rc_osc_node), 32'h0);
    nrst <= 1'b1;
    wait_status(32'h1e, 32'h0);
    close_out();
  end
endmodule : dual_slope_adc_byte_output_port_test
